// [pkg/mtm_map.svh]
// constants for the memory self-test sequencer
`ifndef MTM_MAP_SVH
`define MTM_MAP_SVH

// memory geometry
`define MTM_DW 16
`define MTM_AW 10

// burst program: twelve steps, 0 to 11
`define MTM_STEP_W 4
`define MTM_BURST_LAST 4'hB

// march c-: six elements, descending from element 3
`define MTM_ELEM_LAST 3'h5
`define MTM_ELEM_DOWN 3'h3
`define MTM_MARCH_ACC 16'hA
`define MTM_ACC_W 16

`endif

// [pkg/mtm_pkg.sv]
// types for the memory self-test sequencer
`include "mtm_map.svh"
package mtm_pkg;

  typedef enum logic [1:0] {
    MTM_UM_TRANSPARENT,
    MTM_UM_ONLINE,
    MTM_UM_OFFLINE,
    MTM_UM_PRODUCTION
  } mtm_use_model_t;

  typedef enum logic {MTM_T_BURST, MTM_T_MARCH} mtm_test_t;

  typedef enum logic [1:0] {MTM_DS_FIXED, MTM_DS_FIRST, MTM_DS_SECOND} mtm_data_src_t;

  typedef enum logic [1:0] {MTM_D_FP, MTM_D_NFP, MTM_D_FIRST, MTM_D_SECOND} mtm_dsel_t;

  typedef enum {MTM_ST_IDLE, MTM_ST_BURST, MTM_ST_MARCH} mtm_state_t;

  typedef struct packed {
    logic              rd_en;
    logic [`MTM_AW-1:0] rd_addr;
    logic              wr_en;
    logic [`MTM_AW-1:0] wr_addr;
    logic [`MTM_DW-1:0] wr_data;
  } mtm_mem_req_t;

  typedef struct packed {
    logic      rd;
    logic      rd_odd;
    mtm_dsel_t rd_exp;
    logic      wr;
    logic      wr_odd;
    mtm_dsel_t wr_dat;
    logic      save;
  } mtm_burst_t;

  typedef struct packed {
    logic wr;
    logic inv;
    logic last;
  } mtm_op_t;

endpackage : mtm_pkg

// [rtl/mtm_read_checker.sv]
// read-data compare with sticky failure flag
`timescale 1ns/10ps
`include "mtm_map.svh"
module mtm_read_checker (
  input  logic               clk_sys,
  input  logic               rst,
  input  logic               chk_en,
  input  logic [`MTM_DW-1:0] chk_exp,
  input  logic [`MTM_DW-1:0] rd_data,
  input  logic               clear,
  output logic               fail,
  output logic               mismatch
);

  logic               en_r;
  logic [`MTM_DW-1:0] exp_r;
  logic               fail_r;
  logic               mis_r;

  // one stage aligns the expectation with the returning read data
  wire miss_w = en_r & (rd_data != exp_r);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_r   <= 1'b0;
      exp_r  <= '0;
      fail_r <= 1'b0;
      mis_r  <= 1'b0;
    end else begin
      en_r  <= chk_en;
      exp_r <= chk_exp;
      mis_r <= miss_w;
      // set beats clear so a miss in the clear cycle survives
      if (miss_w) begin
        fail_r <= 1'b1;
      end else if (clear) begin
        fail_r <= 1'b0;
      end
    end
  end

  assign fail     = fail_r;
  assign mismatch = mis_r;

  a_fail_on_miss: assert property (@(posedge clk_sys) disable iff (rst)
    miss_w |=> fail && mismatch)
    else $error("miss did not raise fail");

  a_fail_holds: assert property (@(posedge clk_sys) disable iff (rst)
    (fail && !clear) |=> fail)
    else $error("fail dropped without clear");

endmodule : mtm_read_checker

// [rtl/mtm_sequencer.sv]
// memory self-test sequencer: two-port transparent burst and march c-
`timescale 1ns/10ps
`include "mtm_map.svh"
module mtm_sequencer (
  input  logic                   clk_sys,
  input  logic                   rst,
  input  logic                   start,
  input  mtm_pkg::mtm_test_t     test_sel,
  input  mtm_pkg::mtm_use_model_t use_model,
  input  logic                   run_at_boot,
  input  logic                   start_at_m,
  input  logic [1:0]             column_mux_width,
  input  logic [`MTM_DW-1:0]     fixed_pattern,
  input  logic [`MTM_AW-1:0]     low_bound_address,
  input  logic [`MTM_AW-1:0]     high_bound_address,
  input  mtm_pkg::mtm_data_src_t data_source_select,
  input  logic                   save_wr_en,
  input  logic                   save_wr_sel,
  input  logic [`MTM_DW-1:0]     save_wr_data,
  input  logic [`MTM_DW-1:0]     rd_data,
  output mtm_pkg::mtm_mem_req_t  mem_req,
  output logic                   busy,
  output logic                   done,
  output logic                   start_refused,
  output logic                   fail,
  output logic                   mismatch,
  output logic [`MTM_DW-1:0]     save_reg_first,
  output logic [`MTM_DW-1:0]     save_reg_second
);

  localparam int AW = `MTM_AW;
  localparam int DW = `MTM_DW;
  localparam mtm_pkg::mtm_dsel_t D_FP = mtm_pkg::MTM_D_FP;
  localparam mtm_pkg::mtm_dsel_t D_NFP = mtm_pkg::MTM_D_NFP;
  localparam mtm_pkg::mtm_dsel_t D_SF = mtm_pkg::MTM_D_FIRST;
  localparam mtm_pkg::mtm_dsel_t D_SS = mtm_pkg::MTM_D_SECOND;

  mtm_pkg::mtm_state_t   st_r, st_nxt;
  logic [`MTM_STEP_W-1:0] step_r, step_nxt;
  logic [AW-1:0]         n_r, n_nxt, addr_r, addr_nxt;
  logic [2:0]            elem_r, elem_nxt;
  logic                  op_r, op_nxt;
  mtm_pkg::mtm_mem_req_t req_r, req_nxt;
  logic                  chk_en_r, chk_en_nxt;
  logic [DW-1:0]         chk_exp_r, chk_exp_nxt, sf_r, ss_r;
  logic [1:0]            tag_r, tag_nxt, tag_d_r;
  logic                  done_r, done_nxt, refused_r, boot_pend_r;
  logic [`MTM_ACC_W-1:0] acc_r;
  mtm_pkg::mtm_burst_t   bop_w;
  mtm_pkg::mtm_op_t      mop_w;

  // row-first stepping: add one row, or subtract one when descending; on row wrap move one column the same way
  function automatic logic [AW-1:0] row_step(input logic [AW-1:0] a,
                                             input logic [1:0]    cmw,
                                             input logic          up,
                                             input logic [AW-1:0] lo,
                                             input logic [AW-1:0] hi);
    logic [AW:0]   s;
    logic [AW-1:0] colm;
    logic [AW-1:0] rinc;
    rinc = AW'(1) << cmw;
    colm = rinc - AW'(1);
    s    = up ? ({1'b0, a} + {1'b0, rinc}) : ({1'b0, a} - {1'b0, rinc});
    // rows wrap at the range bounds, not at the end of the address space
    if (up ? (s <= {1'b0, hi}) : (!s[AW] && (s[AW-1:0] >= lo))) begin
      row_step = s[AW-1:0];
    end else if (up) begin
      row_step = (lo & ~colm) | (((a & colm) + AW'(1)) & colm);
    end else begin
      row_step = (hi & ~colm) | (((a & colm) - AW'(1)) & colm);
    end
  endfunction : row_step

  // burst program: read, read-port fields, write, write-port fields, save
  function automatic mtm_pkg::mtm_burst_t burst_tab(input logic [`MTM_STEP_W-1:0] s);
    unique case (s)
      4'h0: burst_tab = '{1'b1, 1'b0, D_FP, 1'b0, 1'b0, D_FP, 1'b1};
      4'h1: burst_tab = '{1'b1, 1'b1, D_FP, 1'b0, 1'b0, D_FP, 1'b1};
      4'h2: burst_tab = '{1'b0, 1'b0, D_FP, 1'b1, 1'b0, D_FP, 1'b0};
      4'h3: burst_tab = '{1'b1, 1'b0, D_FP, 1'b1, 1'b1, D_NFP, 1'b0};
      4'h4: burst_tab = '{1'b1, 1'b1, D_NFP, 1'b1, 1'b0, D_FP, 1'b0};
      4'h5: burst_tab = '{1'b0, 1'b0, D_FP, 1'b1, 1'b0, D_NFP, 1'b0};
      4'h6: burst_tab = '{1'b1, 1'b0, D_NFP, 1'b1, 1'b1, D_FP, 1'b0};
      4'h7: burst_tab = '{1'b1, 1'b1, D_FP, 1'b1, 1'b0, D_NFP, 1'b0};
      4'h8: burst_tab = '{1'b0, 1'b0, D_FP, 1'b1, 1'b0, D_SF, 1'b0};
      4'h9: burst_tab = '{1'b0, 1'b0, D_FP, 1'b1, 1'b1, D_SS, 1'b0};
      4'hA: burst_tab = '{1'b1, 1'b0, D_SF, 1'b0, 1'b0, D_FP, 1'b0};
      4'hB: burst_tab = '{1'b1, 1'b1, D_SS, 1'b0, 1'b0, D_FP, 1'b0};
      default: burst_tab = '{1'b0, 1'b0, D_FP, 1'b0, 1'b0, D_FP, 1'b0};
    endcase
  endfunction : burst_tab

  // march c- elements: write, inverted pattern, last op of the element
  function automatic mtm_pkg::mtm_op_t march_tab(input logic [2:0] e, input logic i);
    unique case (e)
      3'h0:    march_tab = '{1'b1, 1'b0, 1'b1};
      3'h1:    march_tab = '{i, i, i};
      3'h2:    march_tab = '{i, ~i, i};
      3'h3:    march_tab = '{i, i, i};
      3'h4:    march_tab = '{i, ~i, i};
      3'h5:    march_tab = '{1'b0, 1'b0, 1'b1};
      default: march_tab = '{1'b0, 1'b0, 1'b1};
    endcase
  endfunction : march_tab

  function automatic logic [DW-1:0] pick(input mtm_pkg::mtm_dsel_t d,
                                         input logic [DW-1:0]     fp,
                                         input logic [DW-1:0]     sf,
                                         input logic [DW-1:0]     ss);
    unique case (d)
      mtm_pkg::MTM_D_FP:    pick = fp;
      mtm_pkg::MTM_D_NFP:   pick = ~fp;
      mtm_pkg::MTM_D_FIRST: pick = sf;
      mtm_pkg::MTM_D_SECOND: pick = ss;
    endcase
  endfunction : pick

  wire [AW-1:0] m_w = AW'(1) << column_mux_width;
  wire [AW-1:0] nb_w = n_r + m_w;
  wire          idle_w = st_r == mtm_pkg::MTM_ST_IDLE;
  wire          go_w = idle_w & (start | (boot_pend_r & run_at_boot));
  wire          march_sel_w = test_sel == mtm_pkg::MTM_T_MARCH;
  // destroying contents is not allowed while the memory is in service
  wire          refuse_w = go_w & march_sel_w
                           & (use_model == mtm_pkg::MTM_UM_TRANSPARENT);
  wire          launch_w = go_w & ~refuse_w;
  wire [AW+1:0] reach_w = {2'b00, n_r} + {2'b00, m_w} + {1'b0, m_w, 1'b0};
  wire          burst_last_w = reach_w > {2'b00, high_bound_address};
  wire          down_w = elem_r >= `MTM_ELEM_DOWN;
  wire          next_down_w = (elem_r + 3'h1) >= `MTM_ELEM_DOWN;
  wire [AW-1:0] end_w = down_w ? low_bound_address : high_bound_address;
  wire [AW-1:0] stepped_w = row_step(addr_r, column_mux_width, ~down_w,
                                     low_bound_address, high_bound_address);
  wire [DW-1:0] base_w = (data_source_select == mtm_pkg::MTM_DS_FIRST)  ? sf_r :
                         (data_source_select == mtm_pkg::MTM_DS_SECOND) ? ss_r :
                         fixed_pattern;
  wire [DW-1:0] mdat_w = mop_w.inv ? ~base_w : base_w;

  assign bop_w = burst_tab(step_r);
  assign mop_w = march_tab(elem_r, op_r);

  always_comb begin
    st_nxt      = st_r;
    step_nxt    = step_r;
    n_nxt       = n_r;
    addr_nxt    = addr_r;
    elem_nxt    = elem_r;
    op_nxt      = op_r;
    req_nxt     = '0;
    chk_en_nxt  = 1'b0;
    chk_exp_nxt = '0;
    tag_nxt     = 2'h0;
    done_nxt    = 1'b0;
    unique case (st_r)
      mtm_pkg::MTM_ST_IDLE: begin
        if (launch_w) begin
          step_nxt = '0;
          elem_nxt = '0;
          op_nxt   = 1'b0;
          n_nxt    = start_at_m ? m_w : '0;
          addr_nxt = low_bound_address;
          st_nxt   = march_sel_w ? mtm_pkg::MTM_ST_MARCH : mtm_pkg::MTM_ST_BURST;
        end
      end
      mtm_pkg::MTM_ST_BURST: begin
        req_nxt.rd_en   = bop_w.rd;
        req_nxt.rd_addr = bop_w.rd_odd ? nb_w : n_r;
        req_nxt.wr_en   = bop_w.wr;
        req_nxt.wr_addr = bop_w.wr_odd ? nb_w : n_r;
        req_nxt.wr_data = pick(bop_w.wr_dat, fixed_pattern, sf_r, ss_r);
        chk_en_nxt      = bop_w.rd & ~bop_w.save;
        chk_exp_nxt     = pick(bop_w.rd_exp, fixed_pattern, sf_r, ss_r);
        tag_nxt         = {bop_w.rd & bop_w.save, bop_w.rd_odd};
        step_nxt        = step_r + 4'h1;
        if (step_r == `MTM_BURST_LAST) begin
          step_nxt = '0;
          if (burst_last_w) begin
            st_nxt   = mtm_pkg::MTM_ST_IDLE;
            done_nxt = 1'b1;
          end else begin
            n_nxt = n_r + {m_w[AW-2:0], 1'b0};
          end
        end
      end
      mtm_pkg::MTM_ST_MARCH: begin
        req_nxt.rd_en   = ~mop_w.wr;
        req_nxt.rd_addr = addr_r;
        req_nxt.wr_en   = mop_w.wr;
        req_nxt.wr_addr = addr_r;
        req_nxt.wr_data = mdat_w;
        chk_en_nxt      = ~mop_w.wr;
        chk_exp_nxt     = mdat_w;
        op_nxt          = ~mop_w.last;
        if (mop_w.last) begin
          if (addr_r != end_w) begin
            addr_nxt = stepped_w;
          end else if (elem_r == `MTM_ELEM_LAST) begin
            st_nxt   = mtm_pkg::MTM_ST_IDLE;
            done_nxt = 1'b1;
          end else begin
            elem_nxt = elem_r + 3'h1;
            addr_nxt = next_down_w ? high_bound_address : low_bound_address;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r        <= mtm_pkg::MTM_ST_IDLE;
      step_r      <= '0;
      n_r         <= '0;
      addr_r      <= '0;
      elem_r      <= '0;
      op_r        <= 1'b0;
      req_r       <= '0;
      chk_en_r    <= 1'b0;
      chk_exp_r   <= '0;
      tag_r       <= 2'h0;
      tag_d_r     <= 2'h0;
      done_r      <= 1'b0;
      refused_r   <= 1'b0;
      boot_pend_r <= 1'b1;
      acc_r       <= '0;
    end else begin
      st_r        <= st_nxt;
      step_r      <= step_nxt;
      n_r         <= n_nxt;
      addr_r      <= addr_nxt;
      elem_r      <= elem_nxt;
      op_r        <= op_nxt;
      req_r       <= req_nxt;
      chk_en_r    <= chk_en_nxt;
      chk_exp_r   <= chk_exp_nxt;
      tag_r       <= tag_nxt;
      tag_d_r     <= tag_r;
      done_r      <= done_nxt;
      refused_r   <= refuse_w;
      // the boot request is looked at once, in the first idle cycle
      boot_pend_r <= boot_pend_r & ~idle_w;
      acc_r       <= launch_w ? '0 : acc_r + `MTM_ACC_W'(st_r == mtm_pkg::MTM_ST_MARCH);
    end
  end

  // captured read data beats a software write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sf_r <= '0;
      ss_r <= '0;
    end else begin
      if (tag_d_r[1] && !tag_d_r[0]) begin
        sf_r <= rd_data;
      end else if (save_wr_en && !save_wr_sel) begin
        sf_r <= save_wr_data;
      end
      if (tag_d_r[1] && tag_d_r[0]) begin
        ss_r <= rd_data;
      end else if (save_wr_en && save_wr_sel) begin
        ss_r <= save_wr_data;
      end
    end
  end

  mtm_read_checker u_chk (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .chk_en   (chk_en_r),
    .chk_exp  (chk_exp_r),
    .rd_data  (rd_data),
    .clear    (launch_w),
    .fail     (fail),
    .mismatch (mismatch)
  );

  assign mem_req         = req_r;
  assign busy            = ~idle_w;
  assign done            = done_r;
  assign start_refused   = refused_r;
  assign save_reg_first  = sf_r;
  assign save_reg_second = ss_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  wire [`MTM_ACC_W-1:0] ent_w = `MTM_ACC_W'({1'b0, high_bound_address}
                                - {1'b0, low_bound_address}) + `MTM_ACC_W'(1);
  wire [`MTM_ACC_W-1:0] acc_exp_w = `MTM_ACC_W'(`MTM_MARCH_ACC * ent_w);

  sequence s_save_pair;
    (req_r.rd_en && !req_r.wr_en && req_r.rd_addr == n_r) ##1
    (req_r.rd_en && !req_r.wr_en && req_r.rd_addr == n_r + m_w);
  endsequence

  sequence s_restore;
    (req_r.wr_en && !req_r.rd_en && req_r.wr_data == sf_r) ##1
    (req_r.wr_en && !req_r.rd_en && req_r.wr_data == ss_r) ##1
    (req_r.rd_en && !req_r.wr_en && chk_exp_r == sf_r) ##1
    (req_r.rd_en && chk_exp_r == ss_r);
  endsequence

  a_twoport_addr_diff: assert property (
    (req_r.rd_en && req_r.wr_en) |-> req_r.rd_addr != req_r.wr_addr)
    else $error("same-cycle read and write share an address");

  a_twoport_data_inv: assert property (
    (req_r.rd_en && req_r.wr_en) |-> chk_exp_r == ~req_r.wr_data)
    else $error("same-cycle write data not inverse of expected");

  a_burst_save_pair: assert property (
    (st_r == mtm_pkg::MTM_ST_BURST && step_r == 4'h0) |=> s_save_pair)
    else $error("burst did not open with two save reads");

  a_burst_restore: assert property (
    (st_r == mtm_pkg::MTM_ST_BURST && step_r == 4'h8) |=> s_restore)
    else $error("burst restore sequence wrong");

  a_burst_advance: assert property (
    (st_r == mtm_pkg::MTM_ST_BURST && step_r == `MTM_BURST_LAST && !burst_last_w)
    |=> n_r == $past(n_r) + {$past(m_w[AW-2:0]), 1'b0})
    else $error("burst base did not advance by 2m");

  a_loop_last_end: assert property (
    (st_r == mtm_pkg::MTM_ST_BURST && step_r == `MTM_BURST_LAST && burst_last_w)
    |=> idle_w && done_r ##1 !done_r)
    else $error("loop did not end on last entry");

  a_march_refused: assert property (
    refuse_w |=> idle_w && start_refused && !req_r.wr_en)
    else $error("march ran in transparent use model");

  a_march_reload: assert property (
    (st_r == mtm_pkg::MTM_ST_MARCH && mop_w.last && addr_r == end_w
     && elem_r == 3'h2) |=> addr_r == high_bound_address && elem_r == 3'h3)
    else $error("descending element not loaded from high bound");

  a_march_ten_acc: assert property (
    (done_r && $past(st_r == mtm_pkg::MTM_ST_MARCH)) |-> acc_r == acc_exp_w)
    else $error("march access count per entry is not ten");

  a_march_write_pat: assert property (
    (st_r == mtm_pkg::MTM_ST_MARCH && mop_w.wr)
    |=> req_r.wr_en && req_r.wr_addr == $past(addr_r) && req_r.wr_data == $past(mdat_w))
    else $error("march write wrong entry or pattern");

endmodule : mtm_sequencer

// [test/mtm_sram_model.sv]
// two-port sram model: write-only port, read-only port, read latency one
`timescale 1ns/10ps
`include "mtm_map.svh"
module mtm_sram_model (
  input  logic                  clk_sys,
  input  mtm_pkg::mtm_mem_req_t req,
  input  logic                  corrupt,
  output logic [`MTM_DW-1:0]    rd_data
);
  logic [`MTM_DW-1:0] mem [0:(1<<`MTM_AW)-1];
  initial begin
    rd_data = 16'h0000;
    for (int i = 0; i < (1 << `MTM_AW); i++) begin
      mem[i] = 16'hC000 | 16'(i);
    end
  end
  // write port never reads, read port never writes
  always @(posedge clk_sys) begin
    if (req.wr_en) begin
      mem[req.wr_addr] <= req.wr_data;
    end
    // idle read port shows the inverse, so a stale copy never matches
    if (req.rd_en) begin
      rd_data <= mem[req.rd_addr] ^ {15'h0000, corrupt};
    end else begin
      rd_data <= ~rd_data;
    end
  end
endmodule : mtm_sram_model

// [test/tb.sv]
// self-checking bench for the memory self-test sequencer
`timescale 1ns/10ps
`include "mtm_map.svh"
module tb;
  logic                    clk_sys, rst, start, run_at_boot, start_at_m;
  mtm_pkg::mtm_test_t      test_sel;
  mtm_pkg::mtm_use_model_t use_model;
  logic [1:0]              column_mux_width;
  logic [`MTM_DW-1:0]      fixed_pattern, save_wr_data, rd_data;
  logic [`MTM_AW-1:0]      low_bound_address, high_bound_address;
  mtm_pkg::mtm_data_src_t  data_source_select;
  logic                    save_wr_en, save_wr_sel;
  mtm_pkg::mtm_mem_req_t   mem_req;
  logic                    busy, done, start_refused, fail, mismatch;
  logic [`MTM_DW-1:0]      save_reg_first, save_reg_second;
  logic                    corrupt, chk_ovl, seen_miss;
  int                      err_total, n_compared, n_rd, n_wr, n_both;
  logic [`MTM_AW-1:0]      addr_q [$];

  mtm_sequencer i_mtm_sequencer (
    .clk_sys(clk_sys), .rst(rst), .start(start), .test_sel(test_sel),
    .use_model(use_model), .run_at_boot(run_at_boot), .start_at_m(start_at_m),
    .column_mux_width(column_mux_width), .fixed_pattern(fixed_pattern),
    .low_bound_address(low_bound_address), .high_bound_address(high_bound_address),
    .data_source_select(data_source_select), .save_wr_en(save_wr_en),
    .save_wr_sel(save_wr_sel), .save_wr_data(save_wr_data), .rd_data(rd_data),
    .mem_req(mem_req), .busy(busy), .done(done), .start_refused(start_refused),
    .fail(fail), .mismatch(mismatch), .save_reg_first(save_reg_first),
    .save_reg_second(save_reg_second)
  );
  mtm_sram_model i_mtm_sram_model (
    .clk_sys(clk_sys), .req(mem_req), .corrupt(corrupt), .rd_data(rd_data)
  );

  function automatic logic [`MTM_DW-1:0] a16(input logic [`MTM_AW-1:0] a);
    return {6'h00, a};
  endfunction : a16

  task automatic chk(input logic [`MTM_DW-1:0] got, input logic [`MTM_DW-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // sampled mid-cycle, after the registered request has settled
  always @(negedge clk_sys) begin
    if (mem_req.rd_en === 1'b1 || mem_req.wr_en === 1'b1) begin
      addr_q.push_back(mem_req.rd_en ? mem_req.rd_addr : mem_req.wr_addr);
    end
    n_rd += int'(mem_req.rd_en === 1'b1);
    n_wr += int'(mem_req.wr_en === 1'b1);
    if (mismatch === 1'b1) begin
      seen_miss = 1'b1;
    end
    if (chk_ovl && mem_req.rd_en === 1'b1 && mem_req.wr_en === 1'b1) begin
      n_both++;
      chk(a16(mem_req.wr_addr ^ mem_req.rd_addr), 16'h0002);
      chk(mem_req.wr_data, ~i_mtm_sram_model.mem[mem_req.rd_addr]);
    end
  end

  task automatic run_test(input mtm_pkg::mtm_test_t t, input mtm_pkg::mtm_use_model_t u);
    addr_q.delete();
    n_rd = 0;
    n_wr = 0;
    n_both = 0;
    @(posedge clk_sys);
    test_sel <= t;
    use_model <= u;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk_sys);
      if (done === 1'b1) break;
    end
    chk({15'h0000, done}, 16'h0001);
    // compare result trails the last read by two cycles
    repeat (3) @(negedge clk_sys);
  endtask : run_test

  task automatic t_burst();
    chk_ovl = 1'b1;
    run_test(mtm_pkg::MTM_T_BURST, mtm_pkg::MTM_UM_TRANSPARENT);
    chk_ovl = 1'b0;
    chk(16'(n_wr), 16'h0020);
    chk(16'(n_both), 16'h0010);
    chk(16'(addr_q.size()), 16'h0030);
    chk(a16(addr_q[0]), 16'h0000);
    chk(a16(addr_q[1]), 16'h0002);
    chk(save_reg_first, 16'hC00C);
    chk(save_reg_second, 16'hC00E);
    chk({15'h0000, fail}, 16'h0000);
    for (int k = 0; k < 16; k++) begin
      chk(i_mtm_sram_model.mem[k], 16'hC000 | 16'(k));
    end
  endtask : t_burst

  task automatic t_fault();
    corrupt = 1'b1;
    start_at_m <= 1'b1;
    seen_miss = 1'b0;
    run_test(mtm_pkg::MTM_T_BURST, mtm_pkg::MTM_UM_ONLINE);
    corrupt = 1'b0;
    start_at_m <= 1'b0;
    chk({15'h0000, fail}, 16'h0001);
    chk({15'h0000, seen_miss}, 16'h0001);
    chk(a16(addr_q[0]), 16'h0002);
    chk(16'(addr_q.size()), 16'h0024);
  endtask : t_fault

  task automatic t_refuse();
    @(posedge clk_sys);
    test_sel <= mtm_pkg::MTM_T_MARCH;
    use_model <= mtm_pkg::MTM_UM_TRANSPARENT;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    @(negedge clk_sys);
    chk({15'h0000, start_refused}, 16'h0001);
    chk({15'h0000, busy}, 16'h0000);
    @(negedge clk_sys);
    chk({15'h0000, start_refused, busy}, 16'h0000);
  endtask : t_refuse

  task automatic t_march_fixed();
    fixed_pattern <= 16'h3C96;
    run_test(mtm_pkg::MTM_T_MARCH, mtm_pkg::MTM_UM_ONLINE);
    chk(16'(addr_q.size()), 16'h00A0);
    chk(16'(n_rd), 16'h0050);
    chk(a16(addr_q[0]), 16'h0000);
    chk(a16(addr_q[1]), 16'h0002);
    chk(a16(addr_q[8]), 16'h0001);
    chk(a16(addr_q[80]), 16'h000F);
    chk(a16(addr_q[159]), 16'h0000);
    chk({15'h0000, fail}, 16'h0000);
    chk(i_mtm_sram_model.mem[16], 16'hC010);
    for (int k = 0; k < 16; k++) begin
      chk(i_mtm_sram_model.mem[k], 16'h3C96);
    end
  endtask : t_march_fixed

  task automatic t_march_src();
    @(posedge clk_sys);
    save_wr_en <= 1'b1;
    save_wr_sel <= 1'b1;
    save_wr_data <= 16'h1234;
    data_source_select <= mtm_pkg::MTM_DS_SECOND;
    column_mux_width <= 2'h2;
    low_bound_address <= 10'h004;
    @(posedge clk_sys);
    save_wr_en <= 1'b0;
    run_test(mtm_pkg::MTM_T_MARCH, mtm_pkg::MTM_UM_PRODUCTION);
    chk(16'(addr_q.size()), 16'h0078);
    chk(a16(addr_q[0]), 16'h0004);
    chk(a16(addr_q[1]), 16'h0008);
    chk(a16(addr_q[3]), 16'h0005);
    chk(a16(addr_q[60]), 16'h000F);
    chk(save_reg_second, 16'h1234);
    chk({15'h0000, fail}, 16'h0000);
    for (int k = 0; k < 16; k++) begin
      chk(i_mtm_sram_model.mem[k], (k < 4) ? 16'h3C96 : 16'h1234);
    end
    @(posedge clk_sys);
    column_mux_width <= 2'h1;
    low_bound_address <= 10'h000;
  endtask : t_march_src

  task automatic t_boot();
    @(posedge clk_sys);
    rst <= 1'b1;
    run_at_boot <= 1'b1;
    test_sel <= mtm_pkg::MTM_T_MARCH;
    use_model <= mtm_pkg::MTM_UM_OFFLINE;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk({15'h0000, busy}, 16'h0001);
    run_at_boot <= 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk_sys);
      if (done === 1'b1) break;
    end
    chk({15'h0000, done}, 16'h0001);
  endtask : t_boot

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // whole run is well under two thousand cycles
  initial begin
    #(20000 * 4);
    err_total++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    start = 1'b0;
    test_sel = mtm_pkg::MTM_T_BURST;
    use_model = mtm_pkg::MTM_UM_TRANSPARENT;
    run_at_boot = 1'b0;
    start_at_m = 1'b0;
    column_mux_width = 2'h1;
    fixed_pattern = 16'hA5C3;
    low_bound_address = 10'h000;
    high_bound_address = 10'h00F;
    data_source_select = mtm_pkg::MTM_DS_FIXED;
    save_wr_en = 1'b0;
    save_wr_sel = 1'b0;
    save_wr_data = 16'h0000;
    corrupt = 1'b0;
    chk_ovl = 1'b0;
    seen_miss = 1'b0;
    err_total = 0;
    n_compared = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_burst();
    t_fault();
    t_refuse();
    t_march_fixed();
    t_march_src();
    t_boot();
    summarize();
  end
endmodule : tb
